// file: design/gpx_pkg.sv
// Shared constants, state encoding and carrier types for the I2C GPIO expander.
// Assumes a single system clock domain; every pin is synchronised before use.
package gpx_pkg;

  localparam int          NUM_PORTS     = 2;
  localparam int          PORT_W        = 8;
  localparam int          SYNC_W        = 21;

  // Fixed upper part of the 7-bit target address; the low three bits come from pins.
  localparam logic [3:0]  ADDR_PREFIX   = 4'h4;

  // Command byte layout: bit 0 picks the port, bits 2:1 pick the register kind.
  localparam logic [1:0]  KIND_IN       = 2'h0;
  localparam logic [1:0]  KIND_OUT      = 2'h1;
  localparam logic [1:0]  KIND_POL      = 2'h2;
  localparam logic [1:0]  KIND_CFG      = 2'h3;

  localparam logic [7:0]  OUT_RST       = 8'hFF;
  localparam logic [7:0]  POL_RST       = 8'h00;
  localparam logic [7:0]  CFG_RST       = 8'hFF;
  localparam logic [7:0]  HOLD_RST      = 8'h00;

  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  LAST_BIT      = 4'h7;
  localparam logic [3:0]  BIT_STEP      = 4'h1;

  // Shortest legal serial clock period and the oversampling it leaves us.
  localparam int          SYS_CLK_PERIOD_NS = 10;
  localparam int          SCL_MIN_PERIOD_NS = 2500;
  localparam int          SCL_MIN_CYC       = SCL_MIN_PERIOD_NS / SYS_CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_CMD,
    ST_ACK_CMD,
    ST_WDATA,
    ST_ACK_W,
    ST_RDATA,
    ST_RACK
  } gpx_state_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] pol;
    logic [7:0] out;
  } gpx_port_regs_t;

  typedef struct packed {
    logic       en;
    logic [1:0] kind;
    logic [7:0] data;
  } gpx_wr_t;

endpackage

// file: design/gpx_port.sv
// One 8-bit port: output, polarity and direction registers plus the held input value.
// Assumes pins arrive already synchronised and writes arrive pre-gated for this port.
`timescale 1ns/1ps
module gpx_port
  import gpx_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire gpx_wr_t               wr,
  input  wire logic                  snap,
  input  wire logic [PORT_W-1:0]     pins,
  output gpx_port_regs_t             regs,
  output logic      [PORT_W-1:0]     in_val,
  output logic      [PORT_W-1:0]     pin_out,
  output logic      [PORT_W-1:0]     pin_oe,
  output logic      [PORT_W-1:0]     diff
);

  // Two synchroniser stages plus one edge to take the settled pin value.
  localparam int PRIME_W = 3;

  gpx_port_regs_t     regs_ff;
  gpx_port_regs_t     nxt_regs;
  logic [PORT_W-1:0]  hold_ff;
  logic [PORT_W-1:0]  nxt_hold;
  logic [PRIME_W-1:0] prime_ff;
  logic               primed;

  assign nxt_regs.out = (wr.en && wr.kind == KIND_OUT) ? wr.data : regs_ff.out;
  assign nxt_regs.pol = (wr.en && wr.kind == KIND_POL) ? wr.data : regs_ff.pol;
  assign nxt_regs.cfg = (wr.en && wr.kind == KIND_CFG) ? wr.data : regs_ff.cfg;
  // The held value tracks the pins until the synchroniser has filled, so its reset zeros raise no interrupt.
  assign primed       = prime_ff[PRIME_W-1];
  assign nxt_hold     = (!primed || snap) ? pins : hold_ff;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      regs_ff   <= '{cfg: CFG_RST, pol: POL_RST, out: OUT_RST};
      hold_ff   <= HOLD_RST;
      prime_ff  <= '0;
    end else begin
      regs_ff   <= nxt_regs;
      hold_ff   <= nxt_hold;
      prime_ff  <= {prime_ff[PRIME_W-2:0], 1'b1};
    end
  end

  assign regs    = regs_ff;
  assign in_val  = pins ^ regs_ff.pol;
  assign pin_out = regs_ff.out;
  assign pin_oe  = ~regs_ff.cfg;
  // Output pins never flag a change; only inputs are compared against the held value.
  assign diff    = (pins ^ hold_ff) & regs_ff.cfg & {PORT_W{primed}};

endmodule

// file: design/gpx_sync.sv
// Two-flop synchroniser for a vector of independent asynchronous levels.
// Assumes each bit is a slow level; no multi-bit coherence is promised.
`timescale 1ns/1ps
module gpx_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule

// file: design/gpx_top.sv
// I2C target bridging serial transfers to a 16-bit GPIO expander with change interrupt.
// Assumes SCL, SDA, address straps and pins are asynchronous and sampled at 100 MHz.
`timescale 1ns/1ps

// Functional notes
// - Sixteen pins form two eight-bit ports.
// - Per-pin direction bit chooses input or output.
// - Input register samples pins; output register drives.
// - Polarity bit inverts the returned input level.
// - Every register can be read back.
// - Interrupt pulls low on input change.
// - Reset loads defaults and idles the FSM.
// - All pins are inputs after reset.
// - Three straps complete the fixed address.
// - All access goes through I2C target transfers.
module gpx_top
  import gpx_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        addr_select_bit0,
  input  wire logic        addr_select_bit1,
  input  wire logic        addr_select_bit2,
  input  wire logic [15:0] io_in,
  output logic      [15:0] io_out,
  output logic      [15:0] io_oe,
  input  wire logic        irq_in,
  output logic             irq_out,
  output logic             irq_oe
);

  logic [SYNC_W-1:0]  raw;
  logic [SYNC_W-1:0]  synced;
  logic [15:0]        pins;
  logic               sda_s;
  logic               scl_s;
  logic [2:0]         addr_s;
  logic [6:0]         dev_addr;

  logic               scl_q_ff;
  logic               sda_q_ff;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_det;
  logic               stop_det;
  logic               byte_done;
  logic               addr_hit;

  gpx_state_t         state_ff;
  gpx_state_t         nxt_state;
  logic [3:0]         bit_cnt_ff;
  logic [3:0]         nxt_bit_cnt;
  logic [7:0]         shift_ff;
  logic [7:0]         nxt_shift;
  logic [2:0]         ptr_ff;
  logic [2:0]         nxt_ptr;
  logic [2:0]         ptr_next_pair;
  logic               rw_ff;
  logic               nxt_rw;
  logic               sda_drv_ff;
  logic               nxt_sda_drv;
  logic               irq_ff;

  logic               port_sel;
  logic [1:0]         kind;
  logic [7:0]         rd_data;
  logic               load_rd;
  logic               wr_en;
  gpx_wr_t            wr_bus;

  gpx_port_regs_t     regs   [NUM_PORTS];
  logic [PORT_W-1:0]  in_val [NUM_PORTS];
  logic [PORT_W-1:0]  diff   [NUM_PORTS];
  logic [PORT_W-1:0]  pins_sel;
  logic [15:0]        diff_all;

  // Sampling at 100 MHz leaves at least 250 cycles per bit for a legal serial clock.
  assign raw = {addr_select_bit2, addr_select_bit1, addr_select_bit0, scl_in, sda_in, io_in};

  gpx_sync #(
    .W (SYNC_W)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .d       (raw),
    .q       (synced)
  );

  assign pins     = synced[15:0];
  assign sda_s    = synced[16];
  assign scl_s    = synced[17];
  assign addr_s   = synced[20:18];
  assign dev_addr = {ADDR_PREFIX, addr_s};

  assign scl_rise  = scl_s & ~scl_q_ff;
  assign scl_fall  = ~scl_s & scl_q_ff;
  assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign stop_det  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  assign byte_done = scl_fall && (bit_cnt_ff == BITS_PER_BYTE);
  assign addr_hit  = (shift_ff[7:1] == dev_addr);

  assign port_sel      = ptr_ff[0];
  assign kind          = ptr_ff[2:1];
  // The pointer toggles within its register pair, so a two-byte burst covers both ports.
  assign ptr_next_pair = {ptr_ff[2:1], ~ptr_ff[0]};
  assign pins_sel      = port_sel ? pins[15:8] : pins[7:0];

  // Every register kind is returned on reads.
  assign rd_data = (kind == KIND_IN)  ? in_val[port_sel] :
                   (kind == KIND_OUT) ? regs[port_sel].out :
                   (kind == KIND_POL) ? regs[port_sel].pol : regs[port_sel].cfg;

  assign load_rd = scl_fall && ((state_ff == ST_ACK_ADDR && rw_ff) || state_ff == ST_RACK);
  assign wr_en   = byte_done && (state_ff == ST_WDATA);
  assign wr_bus  = '{en: wr_en, kind: kind, data: shift_ff};

  generate
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
      gpx_wr_t port_wr;
      logic    port_snap;

      // Each port owns its own direction, output, polarity and held input.
      assign port_wr   = '{en: wr_bus.en && (port_sel == 1'(i)), kind: wr_bus.kind, data: wr_bus.data};
      // Reading the input register refreshes the held value.
      assign port_snap = load_rd && (kind == KIND_IN) && (port_sel == 1'(i));

      gpx_port u_port (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .wr      (port_wr),
        .snap    (port_snap),
        .pins    (pins[i*PORT_W +: PORT_W]),
        .regs    (regs[i]),
        .in_val  (in_val[i]),
        .pin_out (io_out[i*PORT_W +: PORT_W]),
        .pin_oe  (io_oe[i*PORT_W +: PORT_W]),
        .diff    (diff[i])
      );

      assign diff_all[i*PORT_W +: PORT_W] = diff[i];
    end
  endgenerate

  always_comb begin
    nxt_state   = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift   = shift_ff;
    nxt_ptr     = ptr_ff;
    nxt_rw      = rw_ff;
    nxt_sda_drv = sda_drv_ff;
    if (stop_det) begin
      nxt_state   = ST_IDLE;
      nxt_sda_drv = 1'b0;
    end else if (start_det) begin
      // A repeated start keeps the pointer so a read can follow a command write.
      nxt_state   = ST_ADDR;
      nxt_bit_cnt = '0;
      nxt_sda_drv = 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_sda_drv = 1'b0;
        end
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            nxt_shift   = {shift_ff[6:0], sda_s};
            nxt_bit_cnt = 4'(bit_cnt_ff + BIT_STEP);
          end else if (byte_done) begin
            nxt_bit_cnt = '0;
            nxt_sda_drv = 1'b1;
            if (state_ff == ST_ADDR) begin
              if (addr_hit) begin
                nxt_state = ST_ACK_ADDR;
                nxt_rw    = shift_ff[0];
              end else begin
                nxt_state   = ST_IDLE;
                nxt_sda_drv = 1'b0;
              end
            end else if (state_ff == ST_CMD) begin
              nxt_state = ST_ACK_CMD;
              nxt_ptr   = shift_ff[2:0];
            end else begin
              nxt_state = ST_ACK_W;
              nxt_ptr   = ptr_next_pair;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw_ff) begin
              nxt_state   = ST_RDATA;
              nxt_shift   = rd_data;
              nxt_sda_drv = ~rd_data[7];
            end else begin
              nxt_state   = ST_CMD;
              nxt_sda_drv = 1'b0;
            end
          end
        end
        ST_ACK_CMD, ST_ACK_W: begin
          if (scl_fall) begin
            nxt_state   = ST_WDATA;
            nxt_sda_drv = 1'b0;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_ff == LAST_BIT) begin
              nxt_state   = ST_RACK;
              nxt_bit_cnt = '0;
              nxt_sda_drv = 1'b0;
            end else begin
              nxt_bit_cnt = 4'(bit_cnt_ff + BIT_STEP);
              nxt_shift   = {shift_ff[6:0], 1'b0};
              nxt_sda_drv = ~shift_ff[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              nxt_state = ST_IDLE;
            end else begin
              nxt_ptr = ptr_next_pair;
            end
          end else if (scl_fall) begin
            nxt_state   = ST_RDATA;
            nxt_shift   = rd_data;
            nxt_sda_drv = ~rd_data[7];
          end
        end
        default: begin
          nxt_state   = ST_IDLE;
          nxt_sda_drv = 1'b0;
        end
      endcase
    end
  end

  // Reset puts every register at its default and the bus engine at rest.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= '0;
      shift_ff   <= '0;
      ptr_ff     <= '0;
      rw_ff      <= 1'b0;
      sda_drv_ff <= 1'b0;
      scl_q_ff   <= 1'b0;
      sda_q_ff   <= 1'b0;
      irq_ff     <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff   <= nxt_shift;
      ptr_ff     <= nxt_ptr;
      rw_ff      <= nxt_rw;
      sda_drv_ff <= nxt_sda_drv;
      scl_q_ff   <= scl_s;
      sda_q_ff   <= sda_s;
      irq_ff     <= |diff_all;
    end
  end

  // The interrupt line is open drain and is sensed by nobody inside, so its input is unused.
  assign sda_out = 1'b0;
  assign sda_oe  = sda_drv_ff;
  assign irq_out = 1'b0;
  assign irq_oe  = irq_ff;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_addr_byte;
    state_ff == ST_ADDR && byte_done;
  endsequence

  sequence s_cmd_byte;
    state_ff == ST_CMD && byte_done;
  endsequence

  a_addr_ack_drive: assert property (s_addr_byte ##0 addr_hit |=> sda_oe && state_ff == ST_ACK_ADDR)
    else $error("Matching address was not acknowledged.");
  a_addr_miss_idle: assert property (s_addr_byte ##0 !addr_hit |=> state_ff == ST_IDLE && !sda_oe)
    else $error("Foreign address was not ignored.");
  a_cmd_sets_ptr: assert property (s_cmd_byte |=> ptr_ff == $past(shift_ff[2:0]))
    else $error("Command byte did not load the pointer.");
  a_stop_to_idle: assert property (stop_det |=> state_ff == ST_IDLE && !sda_oe)
    else $error("Stop condition did not return the engine to idle.");
  a_irq_on_change: assert property ((|diff_all) |=> irq_oe)
    else $error("Input change did not pull the interrupt.");
  a_irq_released: assert property (!(|diff_all) |=> !irq_oe)
    else $error("Interrupt held with no input change.");
  a_pol_inverts: assert property (kind == KIND_IN |-> rd_data == (pins_sel ^ regs[port_sel].pol))
    else $error("Input read value ignores polarity inversion.");
  a_read_loaded: assert property (load_rd |=> shift_ff == $past(rd_data) && state_ff == ST_RDATA)
    else $error("Read data was not loaded for transmission.");
  a_dir_drives_oe: assert property (io_oe == ~{regs[1].cfg, regs[0].cfg})
    else $error("Pin enable does not follow direction bits.");
  a_out_drives_pins: assert property (io_out == {regs[1].out, regs[0].out})
    else $error("Pin levels do not follow output register.");
  a_cfg_kept: assert property (!(wr_en && kind == KIND_CFG) |=> $stable({regs[1].cfg, regs[0].cfg}))
    else $error("Direction changed without a host write.");

endmodule

// file: sim/gpx_host.sv
// I2C host model that drives the expander's serial pins as an open-drain bus master.
// Assumes a pull-up on the data line in the bench and the bench clock as its time base.
`timescale 1ns/1ps
module gpx_host (
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // Quarter of a bit; four of them exceed the shortest legal period, so the host never runs fast.
  localparam int QTR = 63;

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic qwait();
    repeat (QTR) @(negedge sys_clk);
  endtask

  // Data is released before the clock rises, so this also serves as a repeated start.
  task automatic start();
    qwait();
    sda_low = 1'b0;
    qwait();
    scl = 1'b1;
    qwait();
    sda_low = 1'b1;
    qwait();
    scl = 1'b0;
  endtask

  task automatic stop();
    qwait();
    sda_low = 1'b1;
    qwait();
    scl = 1'b1;
    qwait();
    sda_low = 1'b0;
    qwait();
  endtask

  task automatic put_bit(input logic b);
    qwait();
    sda_low = ~b;
    qwait();
    scl = 1'b1;
    qwait();
    qwait();
    scl = 1'b0;
  endtask

  task automatic get_bit(output logic b);
    qwait();
    sda_low = 1'b0;
    qwait();
    scl = 1'b1;
    qwait();
    b = sda;
    qwait();
    scl = 1'b0;
  endtask

  // Address and command bytes go out MSB first; the ninth bit is the target's answer.
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    get_bit(ack);
  endtask

  task automatic rbyte(input logic nack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      get_bit(b[i]);
    end
    put_bit(nack);
  endtask
endmodule

// file: sim/gpx_top_bench.sv
// Self-checking bench for the I2C GPIO expander: host model on the serial pins, pin model on the ports.
// Assumes the design package and the host model are compiled before this file.
`timescale 1ns/1ps
module gpx_top_bench;
  localparam int LIMIT = 90000;
  logic        sys_clk;
  logic        rst_b;
  logic [2:0]  strap;
  logic [15:0] ext;
  logic [15:0] io_in;
  logic [15:0] io_out;
  logic [15:0] io_oe;
  logic        sda_out;
  logic        sda_oe;
  logic        irq_out;
  logic        irq_oe;
  logic        scl;
  logic        host_low;
  wire         sda_w;
  logic [15:0] out_m;
  logic [15:0] pol_m;
  logic [15:0] cfg_m;
  logic [15:0] pins_m;
  logic [15:0] prev_m;
  logic [15:0] rd;
  logic        ack;
  int          error_cnt = 0;
  int          compares  = 0;
  int          cyc       = 0;
  integer      seed;

  // Pull-up on the data line: it reads high unless someone pulls it low.
  assign sda_w = ~(host_low | sda_oe);
  // A driven pin reads back its own drive level; an input pin reads the outside level.
  assign io_in = (io_oe & io_out) | (~io_oe & ext);

  gpx_top u_dut (
    .sys_clk          (sys_clk),
    .rst_b            (rst_b),
    .scl_in           (scl),
    .sda_in           (sda_w),
    .sda_out          (sda_out),
    .sda_oe           (sda_oe),
    .addr_select_bit0 (strap[0]),
    .addr_select_bit1 (strap[1]),
    .addr_select_bit2 (strap[2]),
    .io_in            (io_in),
    .io_out           (io_out),
    .io_oe            (io_oe),
    .irq_in           (~irq_oe),
    .irq_out          (irq_out),
    .irq_oe           (irq_oe)
  );

  gpx_host u_host (
    .sys_clk (sys_clk),
    .sda     (sda_w),
    .scl     (scl),
    .sda_low (host_low)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] dev_addr(input logic rd_bit);
    return {gpx_pkg::ADDR_PREFIX, strap, rd_bit};
  endfunction

  // Low byte goes first because the pointer flips bit 0 after each data byte.
  task automatic reg_wr(input logic [7:0] cmd, input logic [15:0] v);
    u_host.start();
    u_host.wbyte(dev_addr(1'b0), ack);
    chk(16'(ack), 16'h0000);
    u_host.wbyte(cmd, ack);
    chk(16'(ack), 16'h0000);
    u_host.wbyte(v[7:0], ack);
    u_host.wbyte(v[15:8], ack);
    chk(16'(ack), 16'h0000);
    u_host.stop();
  endtask

  task automatic reg_rd(input logic [7:0] cmd, output logic [15:0] v);
    u_host.start();
    u_host.wbyte(dev_addr(1'b0), ack);
    u_host.wbyte(cmd, ack);
    u_host.start();
    u_host.wbyte(dev_addr(1'b1), ack);
    chk(16'(ack), 16'h0000);
    u_host.rbyte(1'b0, v[7:0]);
    u_host.rbyte(1'b1, v[15:8]);
    u_host.stop();
  endtask

  task automatic settle();
    repeat (8) @(negedge sys_clk);
    pins_m = (~cfg_m & out_m) | (cfg_m & ext);
  endtask

  initial begin
    seed  = 32'h17e5;
    rst_b = 1'b0;
    ext   = $random(seed);
    strap = $random(seed);
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk(io_oe, 16'h0000);
    chk(io_out, 16'hffff);
    chk({12'h000, irq_out, sda_out, irq_oe, sda_oe}, 16'h0000);
    $display("test reset done");
    out_m = $random(seed);
    cfg_m = ($random(seed) | 16'h0001) & 16'hfeff;
    pol_m = $random(seed);
    reg_wr(8'h02, out_m);
    reg_wr(8'h06, cfg_m);
    reg_wr(8'h04, pol_m);
    settle();
    chk(io_out, out_m);
    chk(io_oe, ~cfg_m);
    $display("test write done");
    reg_rd(8'h03, rd);
    chk(rd, {out_m[7:0], out_m[15:8]});
    reg_rd(8'h06, rd);
    chk(rd, cfg_m);
    $display("test readback done");
    // Only pins set as inputs may raise the interrupt when the outside level moves.
    prev_m = (~cfg_m & out_m) | (cfg_m & ext);
    ext = ext ^ ($random(seed) | 16'h0001);
    settle();
    chk(16'(irq_oe), 16'(|((prev_m ^ pins_m) & cfg_m)));
    reg_rd(8'h00, rd);
    chk(rd, pins_m ^ pol_m);
    settle();
    chk(16'(irq_oe), 16'h0000);
    $display("test input done");
    ext[0] = ~ext[0];
    settle();
    chk(16'(irq_oe), 16'h0001);
    ext[0] = ~ext[0];
    settle();
    chk(16'(irq_oe), 16'h0000);
    ext[8] = ~ext[8];
    ext[0] = ~ext[0];
    settle();
    chk(16'(irq_oe), 16'h0001);
    // A read with no command reuses the pointer; the refused last byte left it on port 1.
    u_host.start();
    u_host.wbyte(dev_addr(1'b1), ack);
    u_host.rbyte(1'b0, rd[7:0]);
    u_host.rbyte(1'b1, rd[15:8]);
    u_host.stop();
    chk(rd, {pins_m[7:0] ^ pol_m[7:0], pins_m[15:8] ^ pol_m[15:8]});
    settle();
    chk(16'(irq_oe), 16'h0000);
    $display("test interrupt done");
    u_host.start();
    u_host.wbyte({gpx_pkg::ADDR_PREFIX, strap ^ 3'h5, 1'b0}, ack);
    u_host.stop();
    chk(16'(ack), 16'h0001);
    chk(io_out, out_m);
    $display("test address done");
    report_and_stop();
  end
endmodule
